/* logic/wasbc_top.sv */
// Overview of operation
// - file-form add sums file register and default work register in one cycle
// - add_with_carry_in adds base, second operand and the carry flag
// - file forms write default work register when selected, else the file register
// - twos_complement_invert gives inverse plus one; bitwise_invert gives inverse only
// - and, inclusive_or, xor over file, lit10, lit5 or register operand pairs
// - arith_shift_right shifts base by literal count, copying the sign bit
// - logical_shift_right shifts base by register count, filling zeros on top
// - rotate_left_via_carry moves carry to bit zero and msb to carry
// - rotate_right_plain moves bit zero to msb, carry untouched
// - shift_left by one, literal or register count, zeros enter low end
// - bit clear, set, toggle and test pick one bit by 4-bit index
// - test_then_set_bit copies bit to carry or its inverse to sticky zero, then sets it
// - find_bit_change_left reports first position differing from the msb
// - first_one_from_msb returns first set bit scanning down from msb
// - first_one_from_lsb returns first set bit scanning up from lsb
// - skip_if_bit_clear skips next instruction when indexed bit is zero
// - skip_if_bit_set skips next instruction when indexed bit is one
// - compare_to_zero updates flags only, no result written
// - compare_with_borrow is base minus source minus inverted carry, flags only
// - skip_if_equal skips on equal operands, skip_if_unequal on differing ones
// - skip_if_signed_greater skips when base is signed greater than second
// - skip_if_signed_less skips when base is signed less than second
// - skips cost one cycle untaken, two over one word, three over two
module wasbc_top (
    input  wire logic                    clk_sys_i,
    input  wire logic                    resetn_i,
    input  wire logic                    req_valid_i,
    input  wire wasbc_pkg::wasbc_req_t   req_i,
    output logic                         ready_o,
    output logic                         res_valid_o,
    output wasbc_pkg::wasbc_res_t        res_o,
    output wasbc_pkg::wasbc_flags_t      flags_o
);

    ////////////////////////////////////////////////////////////////////////
    // operand selection

    function automatic logic [15:0] pick_second(input wasbc_pkg::wasbc_req_t r);
        logic [15:0] v;
        v = r.src;
        unique case (r.form)
            wasbc_pkg::FORM_FILE:  v = r.work;
            wasbc_pkg::FORM_LIT10: v = {6'h00, r.lit};
            wasbc_pkg::FORM_LIT5:  v = {11'h000, r.lit[4:0]};
            wasbc_pkg::FORM_REG:   v = r.src;
        endcase
        return v;
    endfunction : pick_second

    function automatic logic [16:0] add17(input logic [15:0] a, input logic [15:0] b, input logic ci);
        return {1'b0, a} + {1'b0, b} + {16'h0000, ci};
    endfunction : add17

    function automatic logic is_skip_op(input wasbc_pkg::wasbc_op_t op);
        return op inside {wasbc_pkg::OP_SKIP_CLR, wasbc_pkg::OP_SKIP_SET, wasbc_pkg::OP_SKIP_EQ,
                          wasbc_pkg::OP_SKIP_NE, wasbc_pkg::OP_SKIP_GT, wasbc_pkg::OP_SKIP_LT};
    endfunction : is_skip_op

    wasbc_pkg::wasbc_state_t state_q;
    wasbc_pkg::wasbc_state_t state_d;
    wasbc_pkg::wasbc_req_t   req_q;
    wasbc_pkg::wasbc_res_t   res_q;
    wasbc_pkg::wasbc_res_t   res_d;
    wasbc_pkg::wasbc_flags_t flags_q;
    wasbc_pkg::wasbc_flags_t flags_d;
    logic                    res_valid_q;
    logic                    take;
    logic [15:0]             opa;
    logic [15:0]             opb;
    logic                    sel_bit;
    logic [15:0]             bit_mask;
    logic [3:0]              shift_cnt;
    wasbc_pkg::wasbc_shmode_t shift_mode;
    logic [15:0]             shifted;
    logic [3:0]              scan_msb;
    logic [3:0]              scan_lsb;
    logic [3:0]              scan_chg;
    logic                    scan_no_one;
    logic                    scan_no_chg;
    logic [16:0]             sum;
    logic [15:0]             addend;
    logic                    upd_nz;
    logic                    upd_ov;
    logic                    sticky;

    assign ready_o     = (state_q == wasbc_pkg::ST_RUN);
    assign take        = req_valid_i && ready_o;
    assign res_valid_o = res_valid_q;
    assign res_o       = res_q;
    assign flags_o     = flags_q;

    assign opa      = req_i.base;
    assign opb      = pick_second(req_i);
    assign bit_mask = 16'h0001 << req_i.bit_index_field;
    assign sel_bit  = opa[req_i.bit_index_field];

    ////////////////////////////////////////////////////////////////////////
    // shifter and scanner

    always_comb begin
        unique case (req_i.cnt_sel)
            wasbc_pkg::CNT_LIT: shift_cnt = req_i.lit[3:0];
            wasbc_pkg::CNT_REG: shift_cnt = req_i.src[3:0];
            default:            shift_cnt = 4'h1;
        endcase
        unique case (req_i.op)
            wasbc_pkg::OP_SHIFT_LR: shift_mode = wasbc_pkg::SH_LOGIC;
            wasbc_pkg::OP_SHIFT_AR: shift_mode = wasbc_pkg::SH_ARITH;
            default:                shift_mode = wasbc_pkg::SH_LEFT;
        endcase
    end

    wasbc_shift u_shift (
        .data_i  (opa),
        .count_i (shift_cnt),
        .mode_i  (shift_mode),
        .data_o  (shifted)
    );

    wasbc_scan u_scan (
        .data_i      (req_i.src),
        .first_msb_o (scan_msb),
        .first_lsb_o (scan_lsb),
        .change_o    (scan_chg),
        .no_one_o    (scan_no_one),
        .no_change_o (scan_no_chg)
    );

    ////////////////////////////////////////////////////////////////////////
    // execute

    always_comb begin
        res_d             = '0;
        res_d.data        = opa;
        res_d.write       = 1'b1;
        res_d.to_work_reg = (req_i.form == wasbc_pkg::FORM_FILE) && req_i.to_work_reg;
        flags_d           = flags_q;
        addend            = opb;
        sum               = add17(opa, opb, 1'b0);
        upd_nz            = 1'b1;
        upd_ov            = 1'b0;
        sticky            = 1'b0;
        unique case (req_i.op)
            // file add with default work register
            wasbc_pkg::OP_ADD: begin
                upd_ov = 1'b1;
            end
            wasbc_pkg::OP_ADD_CARRY: begin
                sum    = add17(opa, opb, flags_q.carry);
                upd_ov = 1'b1;
                sticky = 1'b1;
            end
            wasbc_pkg::OP_AND:     res_d.data = opa & opb;
            wasbc_pkg::OP_OR_INCL: res_d.data = opa | opb;
            wasbc_pkg::OP_XOR:     res_d.data = opa ^ opb;
            wasbc_pkg::OP_INVERT:  res_d.data = ~opa;
            wasbc_pkg::OP_TWOS: begin
                addend = ~opa;
                sum    = add17(~opa, wasbc_pkg::ZERO_WORD, 1'b1);
                upd_ov = 1'b1;
            end
            wasbc_pkg::OP_SHIFT_L, wasbc_pkg::OP_SHIFT_LR, wasbc_pkg::OP_SHIFT_AR: begin
                res_d.data = shifted;
                if (req_i.cnt_sel == wasbc_pkg::CNT_ONE) begin
                    flags_d.carry = (req_i.op == wasbc_pkg::OP_SHIFT_L) ? opa[15] : opa[0];
                end
            end
            wasbc_pkg::OP_ROT_L_C: begin
                res_d.data    = {opa[14:0], flags_q.carry};
                flags_d.carry = opa[15];
            end
            wasbc_pkg::OP_ROT_L:   res_d.data = {opa[14:0], opa[15]};
            wasbc_pkg::OP_ROT_R_C: begin
                res_d.data    = {flags_q.carry, opa[15:1]};
                flags_d.carry = opa[0];
            end
            wasbc_pkg::OP_ROT_R:   res_d.data = {opa[0], opa[15:1]};
            wasbc_pkg::OP_BIT_CLR: begin
                res_d.data = opa & ~bit_mask;
                upd_nz     = 1'b0;
            end
            wasbc_pkg::OP_BIT_SET: begin
                res_d.data = opa | bit_mask;
                upd_nz     = 1'b0;
            end
            wasbc_pkg::OP_BIT_TGL: begin
                res_d.data = opa ^ bit_mask;
                upd_nz     = 1'b0;
            end
            // test to carry or sticky zero, optional set
            wasbc_pkg::OP_BIT_TEST, wasbc_pkg::OP_BIT_TSET: begin
                upd_nz      = 1'b0;
                res_d.write = (req_i.op == wasbc_pkg::OP_BIT_TSET);
                res_d.data  = opa | bit_mask;
                if (req_i.zero_variant) begin
                    flags_d.sticky_zero_flag = ~sel_bit;
                end else begin
                    flags_d.carry = sel_bit;
                end
            end
            wasbc_pkg::OP_FIND_CHG: begin
                upd_nz        = 1'b0;
                res_d.data    = {12'h000, scan_chg};
                flags_d.carry = scan_no_chg;
            end
            wasbc_pkg::OP_FIRST_MSB: begin
                upd_nz        = 1'b0;
                res_d.data    = {12'h000, scan_msb};
                flags_d.carry = scan_no_one;
            end
            wasbc_pkg::OP_FIRST_LSB: begin
                upd_nz        = 1'b0;
                res_d.data    = {12'h000, scan_lsb};
                flags_d.carry = scan_no_one;
            end
            wasbc_pkg::OP_SKIP_CLR, wasbc_pkg::OP_SKIP_SET: begin
                upd_nz      = 1'b0;
                res_d.write = 1'b0;
                res_d.skip  = (req_i.op == wasbc_pkg::OP_SKIP_SET) ? sel_bit : ~sel_bit;
            end
            // flag-only compares, carry means no borrow
            wasbc_pkg::OP_CMP, wasbc_pkg::OP_CMP_ZERO, wasbc_pkg::OP_CMP_BRW: begin
                res_d.write = 1'b0;
                upd_ov      = 1'b1;
                addend      = (req_i.op == wasbc_pkg::OP_CMP_ZERO) ? ~wasbc_pkg::ZERO_WORD : ~opb;
                sticky      = (req_i.op == wasbc_pkg::OP_CMP_BRW);
                sum         = add17(opa, addend, sticky ? flags_q.carry : 1'b1);
            end
            wasbc_pkg::OP_SKIP_EQ, wasbc_pkg::OP_SKIP_NE, wasbc_pkg::OP_SKIP_GT, wasbc_pkg::OP_SKIP_LT: begin
                upd_nz      = 1'b0;
                res_d.write = 1'b0;
                unique case (req_i.op)
                    wasbc_pkg::OP_SKIP_EQ: res_d.skip = (opa == opb);
                    wasbc_pkg::OP_SKIP_NE: res_d.skip = (opa != opb);
                    wasbc_pkg::OP_SKIP_GT: res_d.skip = ($signed(opa) > $signed(opb));
                    default:               res_d.skip = ($signed(opa) < $signed(opb));
                endcase
            end
            default: begin
                upd_nz      = 1'b0;
                res_d.write = 1'b0;
            end
        endcase
        // arithmetic results drive carry and overflow
        if (upd_ov) begin
            res_d.data       = sum[15:0];
            flags_d.carry    = sum[16];
            // negation overflows only on the most negative word, which maps onto itself
            flags_d.overflow = (req_i.op == wasbc_pkg::OP_TWOS) ? (opa[15] && sum[15])
                                                                : ((opa[15] == addend[15]) && (sum[15] != opa[15]));
        end
        // zero is sticky for carry-chained operations
        if (upd_nz) begin
            flags_d.negative         = res_d.data[15];
            flags_d.sticky_zero_flag = sticky ? (flags_q.sticky_zero_flag && (res_d.data == wasbc_pkg::ZERO_WORD))
                                              : (res_d.data == wasbc_pkg::ZERO_WORD);
        end
        if (!res_d.write) begin
            res_d.to_work_reg = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            res_q       <= '0;
            res_valid_q <= 1'b0;
            req_q       <= '0;
        end else begin
            res_valid_q <= take;
            if (take) begin
                res_q <= res_d;
                req_q <= req_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags_q <= {4{wasbc_pkg::FLAG_RST}};
        end else if (take) begin
            flags_q <= flags_d;
        end
    end

    // skip stalls one cycle per skipped word
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            wasbc_pkg::ST_RUN: begin
                if (take && is_skip_op(req_i.op) && res_d.skip) begin
                    state_d = wasbc_pkg::ST_HOLD_A;
                end
            end
            wasbc_pkg::ST_HOLD_A: state_d = req_q.next_two_word ? wasbc_pkg::ST_HOLD_B : wasbc_pkg::ST_RUN;
            wasbc_pkg::ST_HOLD_B: state_d = wasbc_pkg::ST_RUN;
            default:              state_d = wasbc_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= wasbc_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_skip_seen;
        res_valid_o && res_o.skip;
    endsequence

    a_skip_one_word: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        s_skip_seen and !req_q.next_two_word |-> !ready_o ##1 ready_o)
        else $error("one-word skip did not stall exactly one cycle");

    a_skip_two_word: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        s_skip_seen and req_q.next_two_word |-> !ready_o [*2] ##1 ready_o)
        else $error("two-word skip did not stall exactly two cycles");

    a_no_skip_ready: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        res_valid_o && !res_o.skip |-> ready_o)
        else $error("untaken skip or plain op stalled");

    a_file_add_sum: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        res_valid_o && req_q.op == wasbc_pkg::OP_ADD && req_q.form == wasbc_pkg::FORM_FILE
        |-> res_o.data == 16'(req_q.base + req_q.work) && res_o.write)
        else $error("file add result wrong");

    a_dest_select: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        res_valid_o && res_o.write && req_q.form == wasbc_pkg::FORM_FILE
        |-> res_o.to_work_reg == req_q.to_work_reg)
        else $error("file form destination wrong");

    a_compare_no_write: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        res_valid_o && req_q.op inside {wasbc_pkg::OP_CMP_ZERO, wasbc_pkg::OP_CMP_BRW} |-> !res_o.write)
        else $error("compare wrote a result");

    a_twos_value: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        res_valid_o && req_q.op == wasbc_pkg::OP_TWOS |-> res_o.data == 16'(~req_q.base + 16'h0001))
        else $error("twos complement wrong");

    a_bit_set_done: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        res_valid_o && req_q.op == wasbc_pkg::OP_BIT_SET |-> res_o.data[req_q.bit_index_field])
        else $error("bit set missed its bit");

    a_test_set_carry: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        res_valid_o && req_q.op == wasbc_pkg::OP_BIT_TSET && !req_q.zero_variant
        |-> flags_o.carry == req_q.base[req_q.bit_index_field] && res_o.data[req_q.bit_index_field])
        else $error("test then set carry wrong");

    a_skip_equal: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        res_valid_o && req_q.op == wasbc_pkg::OP_SKIP_EQ && req_q.form == wasbc_pkg::FORM_REG
        |-> res_o.skip == (req_q.base == req_q.src))
        else $error("equal skip decision wrong");

endmodule : wasbc_top

/* pkg/wasbc_pkg.sv */
package wasbc_pkg;

    localparam int unsigned DATA_W      = 16;
    localparam int unsigned IDX_W       = 4;
    localparam int unsigned LIT10_W     = 10;
    localparam int unsigned LIT5_W      = 5;
    localparam logic [15:0] ZERO_WORD   = 16'h0000;
    localparam logic [3:0]  ZERO_IDX    = 4'h0;
    localparam logic [3:0]  MSB_IDX     = 4'hF;
    // skip cost in cycles: not taken, over one word, over two words
    localparam int unsigned SKIP_NONE_CYC = 1;
    localparam int unsigned SKIP_ONE_CYC  = 2;
    localparam int unsigned SKIP_TWO_CYC  = 3;
    localparam logic        FLAG_RST    = 1'b0;

    typedef enum logic [4:0] {
        OP_ADD        = 5'h00, OP_ADD_CARRY  = 5'h01, OP_AND        = 5'h02, OP_OR_INCL    = 5'h03,
        OP_XOR        = 5'h04, OP_INVERT     = 5'h05, OP_TWOS       = 5'h06, OP_SHIFT_L    = 5'h07,
        OP_SHIFT_LR   = 5'h08, OP_SHIFT_AR   = 5'h09, OP_ROT_L_C    = 5'h0A, OP_ROT_L      = 5'h0B,
        OP_ROT_R_C    = 5'h0C, OP_ROT_R      = 5'h0D, OP_BIT_CLR    = 5'h0E, OP_BIT_SET    = 5'h0F,
        OP_BIT_TGL    = 5'h10, OP_BIT_TEST   = 5'h11, OP_BIT_TSET   = 5'h12, OP_FIND_CHG   = 5'h13,
        OP_FIRST_MSB  = 5'h14, OP_FIRST_LSB  = 5'h15, OP_SKIP_CLR   = 5'h16, OP_SKIP_SET   = 5'h17,
        OP_CMP        = 5'h18, OP_CMP_ZERO   = 5'h19, OP_CMP_BRW    = 5'h1A, OP_SKIP_EQ    = 5'h1B,
        OP_SKIP_NE    = 5'h1C, OP_SKIP_GT    = 5'h1D, OP_SKIP_LT    = 5'h1E
    } wasbc_op_t;

    typedef enum logic [1:0] {
        FORM_FILE  = 2'h0,
        FORM_LIT10 = 2'h1,
        FORM_LIT5  = 2'h2,
        FORM_REG   = 2'h3
    } wasbc_form_t;

    typedef enum logic [1:0] {
        CNT_ONE = 2'h0,
        CNT_LIT = 2'h1,
        CNT_REG = 2'h2
    } wasbc_cnt_t;

    typedef enum logic [1:0] {
        SH_LEFT  = 2'h0,
        SH_LOGIC = 2'h1,
        SH_ARITH = 2'h2
    } wasbc_shmode_t;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b001,
        ST_HOLD_A = 3'b010,
        ST_HOLD_B = 3'b100
    } wasbc_state_t;

    typedef struct packed {
        wasbc_op_t          op;
        wasbc_form_t        form;
        wasbc_cnt_t         cnt_sel;
        logic [15:0]        base;
        logic [15:0]        src;
        logic [15:0]        work;
        logic [9:0]         lit;
        logic [3:0]         bit_index_field;
        logic               to_work_reg;
        logic               zero_variant;
        logic               next_two_word;
    } wasbc_req_t;

    typedef struct packed {
        logic [15:0]        data;
        logic               write;
        logic               to_work_reg;
        logic               skip;
    } wasbc_res_t;

    typedef struct packed {
        logic               carry;
        logic               sticky_zero_flag;
        logic               negative;
        logic               overflow;
    } wasbc_flags_t;

endpackage : wasbc_pkg

/* logic/wasbc_shift.sv */
module wasbc_shift (
    input  wire logic [15:0]           data_i,
    input  wire logic [3:0]            count_i,
    input  wire wasbc_pkg::wasbc_shmode_t mode_i,
    output logic      [15:0]           data_o
);

    logic signed [15:0] sdata;

    assign sdata = data_i;

    always_comb begin
        unique case (mode_i)
            wasbc_pkg::SH_LEFT:  data_o = data_i << count_i;
            wasbc_pkg::SH_LOGIC: data_o = data_i >> count_i;
            wasbc_pkg::SH_ARITH: data_o = 16'(sdata >>> count_i);
            default:             data_o = data_i;
        endcase
    end

endmodule : wasbc_shift

/* logic/wasbc_scan.sv */
module wasbc_scan (
    input  wire logic [15:0] data_i,
    output logic      [3:0]  first_msb_o,
    output logic      [3:0]  first_lsb_o,
    output logic      [3:0]  change_o,
    output logic             no_one_o,
    output logic             no_change_o
);

    // priority is set by loop order: the last hit written wins
    always_comb begin
        first_msb_o = wasbc_pkg::ZERO_IDX;
        first_lsb_o = wasbc_pkg::ZERO_IDX;
        change_o    = wasbc_pkg::ZERO_IDX;
        no_one_o    = (data_i == wasbc_pkg::ZERO_WORD);
        no_change_o = 1'b1;
        for (int i = 0; i < 16; i++) begin
            if (data_i[i]) begin
                first_msb_o = 4'(i);
            end
        end
        for (int i = 15; i >= 0; i--) begin
            if (data_i[i]) begin
                first_lsb_o = 4'(i);
            end
        end
        for (int i = 0; i < 15; i++) begin
            if (data_i[i] != data_i[15]) begin
                change_o    = 4'(i);
                no_change_o = 1'b0;
            end
        end
    end

endmodule : wasbc_scan

/* tb/wasbc_dec_model.sv */
module wasbc_dec_model (
    input  wire logic                  clk_sys_i,
    input  wire logic                  go_i,
    input  wire wasbc_pkg::wasbc_req_t cmd_i,
    input  wire logic                  ready_i,
    output logic                       req_valid_o,
    output wasbc_pkg::wasbc_req_t      req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    // operands stay frozen until taken, then turn to junk so a late sample shows up
    always @(posedge clk_sys_i) begin
        if (go_i) begin
            req_valid_o <= 1'b1;
            req_o <= cmd_i;
        end else if (req_valid_o && ready_i) begin
            req_valid_o <= 1'b0;
            req_o <= ~req_o;
        end
    end
endmodule : wasbc_dec_model

/* tb/tb_word_alu_shift_bit_compare.sv */
module tb_word_alu_shift_bit_compare;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [4:0] op; logic [1:0] f; logic [15:0] b, s; logic [9:0] l; logic [15:0] d; logic [3:0] e;
    } wasbc_row_t;
    logic                    clk_sys_i = 1'b0;
    logic                    resetn_i  = 1'b0;
    logic                    go        = 1'b0;
    logic                    req_valid, ready, res_valid;
    wasbc_pkg::wasbc_req_t   cmd = '0;
    wasbc_pkg::wasbc_req_t   req;
    wasbc_pkg::wasbc_res_t   res;
    wasbc_pkg::wasbc_flags_t flg;
    int                      bad_count = 0;
    int                      compares  = 0;
    // e: write, skip, check carry, carry
    wasbc_row_t rows [33] = '{
        '{5'h00,2'h0,16'h1234,16'h0,10'h0,16'h2143,4'h8}, '{5'h00,2'h0,16'hFFFF,16'h0,10'h0,16'h0F0E,4'hB},
        '{5'h01,2'h2,16'h0001,16'h0,10'h3,16'h0005,4'hA}, '{5'h02,2'h1,16'hFFFF,16'h0,10'h3F0,16'h03F0,4'h8},
        '{5'h03,2'h3,16'h0F00,16'h00F0,10'h0,16'h0FF0,4'h8}, '{5'h04,2'h0,16'hFFFF,16'h0,10'h0,16'hF0F0,4'h8},
        '{5'h05,2'h0,16'h00FF,16'h0,10'h0,16'hFF00,4'h8}, '{5'h06,2'h0,16'h0001,16'h0,10'h0,16'hFFFF,4'h8},
        '{5'h09,2'h1,16'h8000,16'h0,10'h4,16'hF800,4'h8}, '{5'h08,2'h2,16'h8000,16'h0004,10'h0,16'h0800,4'h8},
        '{5'h07,2'h0,16'h0001,16'h0,10'h0,16'h0002,4'hA}, '{5'h0A,2'h0,16'h8000,16'h0,10'h0,16'h0000,4'hB},
        '{5'h0D,2'h0,16'h0002,16'h0,10'h0,16'h0001,4'hB}, '{5'h07,2'h2,16'h0001,16'h0003,10'h0,16'h0008,4'h8},
        '{5'h0E,2'h0,16'hFFFF,16'h0,10'hF,16'h7FFF,4'h8}, '{5'h0F,2'h0,16'h0000,16'h0,10'h0,16'h0001,4'h8},
        '{5'h10,2'h0,16'h00FF,16'h0,10'h7,16'h007F,4'h8}, '{5'h12,2'h0,16'h0000,16'h0,10'h3,16'h0008,4'hA},
        '{5'h1A,2'h3,16'h0005,16'h0005,10'h0,16'h0,4'h2}, '{5'h19,2'h0,16'h0000,16'h0,10'h0,16'h0,4'h3},
        '{5'h13,2'h0,16'h0,16'hF000,10'h0,16'h000B,4'h8}, '{5'h14,2'h0,16'h0,16'h0120,10'h0,16'h0008,4'h8},
        '{5'h15,2'h0,16'h0,16'h0120,10'h0,16'h0005,4'h8}, '{5'h11,2'h0,16'h0004,16'h0,10'h2,16'h0,4'h3},
        '{5'h1B,2'h3,16'h0005,16'h0005,10'h0,16'h0,4'h4}, '{5'h1C,2'h3,16'h0005,16'h0005,10'h0,16'h0,4'h0},
        '{5'h1D,2'h3,16'h0001,16'hFFFF,10'h0,16'h0,4'h4}, '{5'h1E,2'h3,16'hFFFF,16'h0001,10'h0,16'h0,4'h4},
        '{5'h16,2'h0,16'h0000,16'h0,10'h2,16'h0,4'h4}, '{5'h17,2'h0,16'h0004,16'h0,10'h2,16'h0,4'h4},
        '{5'h18,2'h2,16'h0003,16'h0,10'h5,16'h0,4'h2}, '{5'h0B,2'h0,16'h8000,16'h0,10'h0,16'h0001,4'h8},
        '{5'h0C,2'h0,16'h0001,16'h0,10'h0,16'h0000,4'hB}};
    wasbc_dec_model dec_u (.clk_sys_i(clk_sys_i), .go_i(go), .cmd_i(cmd), .ready_i(ready), .req_valid_o(req_valid),
        .req_o(req));
    wasbc_top dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_valid_i(req_valid), .req_i(req),
        .ready_o(ready), .res_valid_o(res_valid), .res_o(res), .flags_o(flg));
    always #2 clk_sys_i = ~clk_sys_i;
    ////////////////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("compares %0d bad %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    // one word of work register keeps file forms distinct from register forms
    function automatic wasbc_pkg::wasbc_req_t mk(input wasbc_row_t r);
        wasbc_pkg::wasbc_req_t q;
        q = '0;
        q.op = wasbc_pkg::wasbc_op_t'(r.op);
        q.form = wasbc_pkg::wasbc_form_t'(r.f);
        q.cnt_sel = wasbc_pkg::wasbc_cnt_t'(r.f);
        q.base = r.b;
        q.src = r.s;
        q.work = 16'h0F0F;
        q.lit = r.l;
        q.bit_index_field = r.l[3:0];
        return q;
    endfunction : mk
    task automatic run(input wasbc_pkg::wasbc_req_t c);
        @(posedge clk_sys_i);
        cmd <= c;
        go <= 1'b1;
        @(posedge clk_sys_i);
        go <= 1'b0;
        for (int i = 0; i < 9 && res_valid !== 1'b1; i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        chk(16'(res_valid), 16'h1);
    endtask : run
    ////////////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        wasbc_pkg::wasbc_req_t q;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(16'({ready, res_valid, flg}), 16'h20);
        @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        $display("reset test done");
        foreach (rows[i]) begin
            run(mk(rows[i]));
            if (rows[i].e[3]) chk(res.data, rows[i].d);
            chk(16'({res.write, res.skip}), 16'(rows[i].e[3:2]));
            if (rows[i].e[1]) chk(16'(flg.carry), 16'(rows[i].e[0]));
            $display("row %0d done", i);
        end
        for (int t = 0; t < 2; t++) begin
            q = mk(rows[24]);
            q.next_two_word = t[0];
            run(q);
            for (int k = 0; k <= t; k++) begin
                chk(16'(ready), 16'h0);
                @(posedge clk_sys_i);
                #1;
            end
            chk(16'(ready), 16'h1);
        end
        q = mk(rows[0]);
        q.to_work_reg = 1'b1;
        run(q);
        chk(16'({res.write, res.to_work_reg}), 16'h3);
        q = mk(rows[17]);
        q.zero_variant = 1'b1;
        run(q);
        chk(16'(flg.sticky_zero_flag), 16'h1);
        run(mk(rows[7]));
        chk(16'({flg.negative, flg.overflow}), 16'h2);
        q = mk(rows[7]);
        q.base = 16'h8000;
        run(q);
        chk(16'({flg.negative, flg.overflow}), 16'h3);
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        #1;
        chk(16'({ready, res_valid, flg}), 16'h20);
        chk(res.data, 16'h0000);
        @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        run(mk(rows[0]));
        chk(res.data, 16'h2143);
        $display("hand tests done");
        test_done();
    end
    // about 40 requests of at most 6 cycles each need under 1.1 us
    initial begin
        #20000;
        bad_count++;
        test_done();
    end
endmodule : tb_word_alu_shift_bit_compare
